/* design/ims_i2c_master_sequencer.sv */
// Two-wire bus master sequencer with its register port
// Functional notes
// - A transfer ends by Stop or Repeated Start; Repeated Start keeps the bus held.
// - Transmit: address with direction 0, then 8-bit bytes, acknowledge received each.
// - Receive: address with direction 1, then 8-bit bytes, acknowledge sent each.
// - Released clock pauses the baud counter until high, then reload and count.
// - Buffer write during any sequence sets write collision, buffer kept.
// - Sequence enable bits ignore writes until the Start has finished.
// - Start: both lines high, count; still high at timeout, data low, flag start.
// - Then reload, at timeout clear start enable, stop counter, hold data low.
// - Lines low at begin or clock low early: collision flag, abort, idle.
// - Repeated start: clock low, data released one period, then clock released.
// - Then data low one period, clock low, clear enable, interrupt after timeout.
// - Repeated start enable is ignored while another event runs.
// - Repeated start collision: data low at clock rise, or clock drops early.
// - Buffer write sets buffer full; bits placed after fall, low and high periods.
// - After eighth clock fall, clear buffer full and release data for acknowledge.
// - Ninth clock rise captures acknowledge: low clears status, high sets it.
// - After ninth clock set interrupt, stop counter, clock low until next write.
// - Address byte: seven address bits then direction bit, one per clock fall.
// - Stop: data low, count, release clock, release data, flag, clear, interrupt.
// - Receive end: clear enable, load buffer, set full and interrupt, hold clock.
//
// The implementer's own choices: strobed register access and the address map.
module ims_i2c_master_sequencer (
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  input  wire logic [ims_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [ims_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [ims_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        scl_i,
  output logic                             scl_o,
  output logic                             scl_oe,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe,
  output logic                             busy
);
  import ims_pkg::*;

  logic [1:0]                scl_sy_q;
  logic [1:0]                sda_sy_q;
  ims_state_t                state_q;
  ims_state_t                state_d;
  logic [BAUD_W-1:0]         cnt_q;
  logic [BAUD_W-1:0]         cnt_d;
  logic [BAUD_W-1:0]         baud_q;
  logic [3:0]                bit_q;
  logic [3:0]                bit_d;
  logic [DATA_W-1:0]         sh_q;
  logic [DATA_W-1:0]         sh_d;
  logic [DATA_W-1:0]         buf_q;
  logic [DATA_W-1:0]         reg_rdata_q;
  ims_ctrl_t                 ctrl_q;
  ims_ctrl_t                 ctrl_d;
  ims_flag_t                 flag_q;
  ims_flag_t                 flag_set;
  ims_flag_t                 flag_clr;
  logic [4:0]                en_clr;
  logic                      ack_stat_q;
  logic                      bf_q;
  logic                      hi_seen_q;
  logic                      hold_scl_q;
  logic                      hold_scl_d;
  logic                      hold_sda_q;
  logic                      hold_sda_d;
  logic                      scl_oe_q;
  logic                      sda_oe_q;
  logic                      scl_drv;
  logic                      sda_drv;
  logic                      busy_q;
  logic                      clr_bf;
  logic                      rx_load;
  logic                      ack_cap;
  logic                      bcol_ev;

  wire scl_s      = scl_sy_q[1];
  wire sda_s      = sda_sy_q[1];
  wire tick       = (cnt_q == {BAUD_W{1'b0}});
  wire seq_pend   = |(ctrl_q[4:0] & SEQ_MASK);
  wire idle_free  = (state_q == S_IDLE) && !seq_pend;
  wire buf_wr     = reg_wr && (reg_addr == ADDR_BUF);
  wire buf_rd     = reg_rd && (reg_addr == ADDR_BUF);
  wire ctrl_wr    = reg_wr && (reg_addr == ADDR_CTRL);
  wire flag_wr    = reg_wr && (reg_addr == ADDR_FLAG);
  wire baud_wr    = reg_wr && (reg_addr == ADDR_BAUD);
  wire tx_go      = buf_wr && idle_free;
  wire write_collision_flag_ev    = buf_wr && !idle_free;
  wire ctrl_lock  = !idle_free;
  wire is_high    = (state_q == S_RS_HIGH) || (state_q == S_TX_HIGH) ||
                    (state_q == S_RX_HIGH) || (state_q == S_AK_HIGH) ||
                    (state_q == S_SP_HIGH);
  wire is_rel     = (state_q == S_SP_REL);
  wire line_up    = is_high ? scl_s : (is_rel && scl_s && sda_s);
  wire rise       = (is_high || is_rel) && line_up && !hi_seen_q;
  wire hi_seen_d  = (state_d == state_q) && (hi_seen_q || ((is_high || is_rel) && line_up));
  wire [DATA_W-1:0] rd_val =
    (reg_addr == ADDR_BUF)  ? buf_q :
    (reg_addr == ADDR_CTRL) ? {1'b0, ack_stat_q, ctrl_q} :
    (reg_addr == ADDR_STAT) ? {6'h00, busy_q, bf_q} :
    (reg_addr == ADDR_FLAG) ? {3'h0, flag_q} :
    (reg_addr == ADDR_BAUD) ? baud_q : DATA_ZERO;

  // Pin sampling, the first stage feeds only the second
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
    end
    else
    begin
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
    end
  end

  // Sequencer: every state transition reloads the baud counter
  always_comb
  begin
    state_d    = state_q;
    cnt_d      = tick ? cnt_q : cnt_q - BAUD_ONE;
    bit_d      = bit_q;
    sh_d       = sh_q;
    hold_scl_d = hold_scl_q;
    hold_sda_d = hold_sda_q;
    flag_set   = '0;
    en_clr     = 5'h00;
    clr_bf     = 1'b0;
    rx_load    = 1'b0;
    ack_cap    = 1'b0;
    bcol_ev    = 1'b0;
    if ((is_high || is_rel) && !hi_seen_q)
      cnt_d = baud_q;
    case (state_q)
      S_IDLE:
      begin
        cnt_d = baud_q;
        if (tx_go)
        begin
          state_d = S_TX_LOW;
          sh_d    = reg_wdata;
          bit_d   = BIT_FIRST;
        end
        else if (ctrl_q.start_enable_bit)
        begin
          if (!scl_s && !sda_s)
            bcol_ev = 1'b1;
          else if (scl_s && sda_s)
            state_d = S_ST_WAIT;
        end
        else if (ctrl_q.repeated_start_enable_bit)
          state_d = S_RS_LOW;
        else if (ctrl_q.stop_enable_bit)
          state_d = S_SP_LOW;
        else if (ctrl_q.receive_enable_bit)
        begin
          state_d = S_RX_LOW;
          bit_d   = BIT_FIRST;
        end
        else if (ctrl_q.ack_sequence_enable_bit)
          state_d = S_AK_LOW;
      end
      S_ST_WAIT:
        if (!scl_s)
          bcol_ev = 1'b1;
        else if (tick)
        begin
          if (sda_s)
          begin
            state_d                 = S_ST_HOLD;
            flag_set.start_detected = 1'b1;
          end
          else
            bcol_ev = 1'b1;
        end
      S_ST_HOLD:
        if (tick)
        begin
          state_d                             = S_IDLE;
          en_clr[0]                           = 1'b1;
          flag_set.serial_port_interrupt_flag = 1'b1;
          hold_scl_d                          = 1'b0;
          hold_sda_d                          = 1'b1;
        end
      S_RS_LOW:
        if (tick)
        begin
          if (sda_s)
            state_d = S_RS_HIGH;
          else
            bcol_ev = 1'b1;
        end
      S_RS_HIGH:
        if (rise && !sda_s)
          bcol_ev = 1'b1;
        else if (hi_seen_q && !scl_s)
          bcol_ev = 1'b1;
        else if (hi_seen_q && tick)
        begin
          state_d                 = S_RS_SDA;
          flag_set.start_detected = 1'b1;
        end
      S_RS_SDA:
        if (!scl_s)
          bcol_ev = 1'b1;
        else if (tick)
        begin
          state_d                             = S_IDLE;
          en_clr[1]                           = 1'b1;
          flag_set.serial_port_interrupt_flag = 1'b1;
          hold_scl_d                          = 1'b1;
          hold_sda_d                          = 1'b1;
        end
      S_TX_LOW:
        if (tick)
          state_d = S_TX_HIGH;
      S_TX_HIGH:
      begin
        if (rise && (bit_q == BIT_ACK))
          ack_cap = 1'b1;
        if (hi_seen_q && tick)
        begin
          if (bit_q == BIT_ACK)
          begin
            state_d                             = S_IDLE;
            flag_set.serial_port_interrupt_flag = 1'b1;
            hold_scl_d                          = 1'b1;
            hold_sda_d                          = 1'b0;
          end
          else
          begin
            state_d = S_TX_LOW;
            bit_d   = bit_q + BIT_ONE;
            sh_d    = {sh_q[DATA_W-2:0], 1'b0};
            clr_bf  = (bit_q == BIT_LAST);
          end
        end
      end
      S_RX_LOW:
        if (tick)
          state_d = S_RX_HIGH;
      S_RX_HIGH:
      begin
        if (rise)
          sh_d = {sh_q[DATA_W-2:0], sda_s};
        if (hi_seen_q && tick)
        begin
          if (bit_q == BIT_LAST)
          begin
            state_d                             = S_IDLE;
            rx_load                             = 1'b1;
            en_clr[3]                           = 1'b1;
            flag_set.serial_port_interrupt_flag = 1'b1;
            hold_scl_d                          = 1'b1;
            hold_sda_d                          = 1'b0;
          end
          else
          begin
            state_d = S_RX_LOW;
            bit_d   = bit_q + BIT_ONE;
          end
        end
      end
      S_AK_LOW:
        if (tick)
          state_d = S_AK_HIGH;
      S_AK_HIGH:
        if (hi_seen_q && tick)
        begin
          state_d                             = S_IDLE;
          en_clr[4]                           = 1'b1;
          flag_set.serial_port_interrupt_flag = 1'b1;
          hold_scl_d                          = 1'b1;
          // Keep the acknowledge level so data does not move as the clock falls
          hold_sda_d                          = !ctrl_q.ack_data_value_bit;
        end
      S_SP_LOW:
        if (tick)
          state_d = S_SP_HIGH;
      S_SP_HIGH:
        if (hi_seen_q && tick)
          state_d = S_SP_REL;
      S_SP_REL:
      begin
        if (rise)
          flag_set.stop_detected = 1'b1;
        if (hi_seen_q && tick)
        begin
          state_d                             = S_IDLE;
          en_clr[2]                           = 1'b1;
          flag_set.serial_port_interrupt_flag = 1'b1;
          hold_scl_d                          = 1'b0;
          hold_sda_d                          = 1'b0;
        end
      end
      default:
        state_d = S_IDLE;
    endcase
    if (bcol_ev)
    begin
      state_d                     = S_IDLE;
      en_clr                      = 5'h03;
      flag_set.bus_collision_flag = 1'b1;
      hold_scl_d                  = 1'b0;
      hold_sda_d                  = 1'b0;
    end
    if (state_d != state_q)
      cnt_d = baud_q;
    flag_set.write_collision_flag = write_collision_flag_ev;
  end

  // Line drive per state; enable high pulls the line low
  always_comb
  begin
    scl_drv = 1'b0;
    sda_drv = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        scl_drv = hold_scl_q;
        sda_drv = hold_sda_q;
      end
      S_ST_HOLD: sda_drv = 1'b1;
      S_RS_LOW:  scl_drv = 1'b1;
      S_RS_SDA:  sda_drv = 1'b1;
      S_TX_LOW,
      S_TX_HIGH:
      begin
        scl_drv = (state_q == S_TX_LOW);
        sda_drv = (bit_q < BIT_ACK) && !sh_q[DATA_W-1];
        // First low cycle keeps the old level so data moves after the clock falls
        if ((state_q == S_TX_LOW) && (cnt_q == baud_q))
          sda_drv = sda_oe_q;
      end
      S_RX_LOW:  scl_drv = 1'b1;
      S_AK_LOW,
      S_AK_HIGH:
      begin
        scl_drv = (state_q == S_AK_LOW);
        sda_drv = !ctrl_q.ack_data_value_bit;
      end
      S_SP_LOW:
      begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
      end
      S_SP_HIGH: sda_drv = 1'b1;
      default:
      begin
        scl_drv = 1'b0;
        sda_drv = 1'b0;
      end
    endcase
  end

  assign flag_clr = flag_wr ? ims_flag_t'(reg_wdata[4:0]) : '0;

  always_comb
  begin
    ctrl_d                    = ctrl_q;
    ctrl_d[4:0]               = ctrl_q[4:0] & ~en_clr;
    if (ctrl_wr)
      ctrl_d.ack_data_value_bit = reg_wdata[5];
    if (ctrl_wr && !ctrl_lock)
      ctrl_d[4:0]             = reg_wdata[4:0] & SEQ_MASK;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q    <= S_IDLE;
      cnt_q      <= BAUD_RST;
      bit_q      <= BIT_FIRST;
      sh_q       <= DATA_ZERO;
      hi_seen_q  <= 1'b0;
      hold_scl_q <= 1'b0;
      hold_sda_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      bit_q      <= bit_d;
      sh_q       <= sh_d;
      hi_seen_q  <= hi_seen_d;
      hold_scl_q <= hold_scl_d;
      hold_sda_q <= hold_sda_d;
    end
  end

  // Software-visible state; hardware sets win over clears
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q      <= '0;
      flag_q      <= '0;
      baud_q      <= BAUD_RST;
      buf_q       <= DATA_ZERO;
      bf_q        <= 1'b0;
      ack_stat_q  <= 1'b0;
      reg_rdata_q <= DATA_ZERO;
      busy_q      <= 1'b0;
      scl_oe_q    <= 1'b0;
      sda_oe_q    <= 1'b0;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      flag_q      <= (flag_q & ~flag_clr) | flag_set;
      baud_q      <= baud_wr ? reg_wdata : baud_q;
      buf_q       <= rx_load ? sh_d : (tx_go ? reg_wdata : buf_q);
      bf_q        <= tx_go || rx_load || (bf_q && !clr_bf && !buf_rd);
      ack_stat_q  <= ack_cap ? sda_s : ack_stat_q;
      reg_rdata_q <= reg_rd ? rd_val : DATA_ZERO;
      busy_q      <= (state_d != S_IDLE);
      scl_oe_q    <= scl_drv;
      sda_oe_q    <= sda_drv;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign scl_oe    = scl_oe_q;
  assign sda_oe    = sda_oe_q;
  assign busy      = busy_q;
  // Output levels are fixed low flops: the lines are open drain
  logic scl_o_q;
  logic sda_o_q;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
    end
    else
    begin
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
    end
  end
  assign scl_o = scl_o_q;
  assign sda_o = sda_o_q;

  chk_write_collision_flag_set: assert property (@(posedge clock) disable iff (!rst_b)
    write_collision_flag_ev |=> flag_q.write_collision_flag)
    else $error("refused buffer write did not flag a collision");

  chk_buf_kept: assert property (@(posedge clock) disable iff (!rst_b)
    (buf_wr && (state_q != S_IDLE)) |=> $stable(buf_q) || $past(rx_load))
    else $error("buffer changed on a refused write");

  chk_bf_on_write: assert property (@(posedge clock) disable iff (!rst_b)
    tx_go |=> bf_q && (state_q == S_TX_LOW) && (buf_q == $past(reg_wdata)))
    else $error("accepted write did not start a byte");

  chk_cnt_paused: assert property (@(posedge clock) disable iff (!rst_b)
    (is_high && !scl_s && !hi_seen_q && (state_d == state_q)) |=> (cnt_q == baud_q))
    else $error("baud counter ran while the clock was held low");

  chk_start_done: assert property (@(posedge clock) disable iff (!rst_b)
    ((state_q == S_ST_HOLD) && tick) |=>
      !ctrl_q.start_enable_bit && flag_q.serial_port_interrupt_flag ##1 sda_oe_q)
    else $error("start did not finish with data held low");

  chk_ack_capture: assert property (@(posedge clock) disable iff (!rst_b)
    ((state_q == S_TX_HIGH) && rise && (bit_q == BIT_ACK)) |=> (ack_stat_q == $past(sda_s)))
    else $error("acknowledge status not captured");

  chk_ctrl_locked: assert property (@(posedge clock) disable iff (!rst_b)
    (ctrl_wr && (state_q == S_ST_WAIT)) |=> (ctrl_q[1:0] == $past(ctrl_q[1:0])))
    else $error("sequence enables changed during a start");

  chk_tx_bit: assert property (@(posedge clock) disable iff (!rst_b)
    ((state_q == S_TX_LOW) && (bit_q < BIT_ACK) && (cnt_q != baud_q)) |=>
      (sda_oe_q == !$past(sh_q[DATA_W-1])))
    else $error("transmitted bit does not follow the shift register");

  chk_tx_hold: assert property (@(posedge clock) disable iff (!rst_b)
    ((state_q == S_TX_LOW) && (cnt_q == baud_q) && !tick) |=> $stable(sda_oe_q))
    else $error("data moved in the cycle in which the clock fell");

  chk_start_bcol: assert property (@(posedge clock) disable iff (!rst_b)
    ((state_q == S_IDLE) && ctrl_q.start_enable_bit && !tx_go && !scl_s && !sda_s) |=>
      flag_q.bus_collision_flag && (state_q == S_IDLE) && !ctrl_q.start_enable_bit)
    else $error("start on a low bus did not flag a collision");

  chk_rx_end: assert property (@(posedge clock) disable iff (!rst_b)
    rx_load |=> bf_q && !ctrl_q.receive_enable_bit && (state_q == S_IDLE) ##1 scl_oe_q)
    else $error("receive end did not load buffer and hold the clock");

  cov_start: cover property (@(posedge clock) disable iff (!rst_b)
    (state_q == S_ST_HOLD) ##1 (state_q == S_IDLE));
  cov_tx_byte: cover property (@(posedge clock) disable iff (!rst_b)
    (state_q == S_TX_HIGH) && (bit_q == BIT_ACK) ##1 (state_q == S_IDLE));
  cov_rx_byte: cover property (@(posedge clock) disable iff (!rst_b) rx_load);
  cov_stop: cover property (@(posedge clock) disable iff (!rst_b)
    (state_q == S_SP_REL) ##1 (state_q == S_IDLE));
endmodule

/* design/ims_pkg.sv */
// Constants, field layouts and types shared by the bus sequencer
package ims_pkg;
  localparam int            ADDR_W       = 3;
  localparam int            DATA_W       = 8;
  localparam int            BAUD_W       = 8;
  localparam logic [2:0]    ADDR_BUF     = 3'h0;
  localparam logic [2:0]    ADDR_CTRL    = 3'h1;
  localparam logic [2:0]    ADDR_STAT    = 3'h2;
  localparam logic [2:0]    ADDR_FLAG    = 3'h3;
  localparam logic [2:0]    ADDR_BAUD    = 3'h4;
  localparam logic [7:0]    BAUD_RST     = 8'h09;
  localparam logic [7:0]    BAUD_ONE     = 8'h01;
  localparam logic [7:0]    DATA_ZERO    = 8'h00;
  localparam logic [3:0]    BIT_FIRST    = 4'h0;
  localparam logic [3:0]    BIT_ONE      = 4'h1;
  localparam logic [3:0]    BIT_LAST     = 4'h7;
  localparam logic [3:0]    BIT_ACK      = 4'h8;
  localparam logic [4:0]    SEQ_MASK     = 5'h1f;
  localparam int            CTRL_ACK_POS = 6;
  localparam int            STAT_BF_POS  = 0;
  localparam int            STAT_BSY_POS = 1;

  // Second control register, low five bits are sequence enables
  typedef struct packed {
    logic ack_data_value_bit;
    logic ack_sequence_enable_bit;
    logic receive_enable_bit;
    logic stop_enable_bit;
    logic repeated_start_enable_bit;
    logic start_enable_bit;
  } ims_ctrl_t;

  // Sticky flags, write one to clear
  typedef struct packed {
    logic stop_detected;
    logic start_detected;
    logic bus_collision_flag;
    logic write_collision_flag;
    logic serial_port_interrupt_flag;
  } ims_flag_t;

  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_ST_WAIT = 4'h1,
    S_ST_HOLD = 4'h2,
    S_RS_LOW  = 4'h3,
    S_RS_HIGH = 4'h4,
    S_RS_SDA  = 4'h5,
    S_TX_LOW  = 4'h6,
    S_TX_HIGH = 4'h7,
    S_RX_LOW  = 4'h8,
    S_RX_HIGH = 4'h9,
    S_AK_LOW  = 4'ha,
    S_AK_HIGH = 4'hb,
    S_SP_LOW  = 4'hc,
    S_SP_HIGH = 4'hd,
    S_SP_REL  = 4'he
  } ims_state_t;
endpackage

/* tb/ims_slave_model.sv */
// Behavioural slave on the two-wire bus: address match, acknowledge, byte return
module ims_slave_model #(
  parameter logic [6:0] DEV = 7'h2a
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       stretch,
  input  wire logic [7:0] tx_byte,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt = 0;
  logic sel = 1'b0;
  logic rd  = 1'b0;
  logic adr = 1'b0;
  initial {scl_pull, sda_pull, rx_byte} = '0;
  // Start or repeated start restarts the address phase
  always @(negedge sda)
    if (scl)
      {cnt, adr, sel} = {32'd0, 2'b10};
  // Stop releases the bus
  always @(posedge sda)
    if (scl)
      {sel, sda_pull} = 2'b00;
  always @(posedge scl)
  begin
    if (cnt < 8)
      rx_byte = {rx_byte[6:0], sda};
    // A not-acknowledge on a read ends the slave's turn
    if ((cnt == 8) && rd && !adr && sda)
      sel = 1'b0;
    cnt++;
  end
  always @(negedge scl)
  begin
    if (cnt == 8)
    begin
      if (adr)
        {sel, rd} = {rx_byte[7:1] == DEV, rx_byte[0]};
      sda_pull = sel && (adr || !rd);
    end
    else
    begin
      if (cnt == 9)
        {cnt, adr} = '0;
      sda_pull = sel && rd && !tx_byte[7 - cnt];
    end
    // Hold the clock low a while when asked to stretch
    if (stretch)
    begin
      scl_pull = 1'b1;
      #400 scl_pull = 1'b0;
    end
  end
endmodule

/* tb/tb_ims_i2c_master_sequencer.sv */
// Self-checking bench for the two-wire master sequencer
module tb_ims_i2c_master_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import ims_pkg::*;
  localparam logic [6:0] DEV = 7'h2a;
  logic       clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, t_pull = 0, stretch = 0;
  logic [2:0] reg_addr  = '0;
  logic [7:0] reg_wdata = '0, tx_byte = '0;
  logic [7:0] reg_rdata, rx_byte, f, d;
  logic       scl_oe, sda_oe, busy, s_scl, s_sda, scl_lv, sda_lv;
  wire        scl = ~(scl_oe | s_scl | t_pull);
  wire        sda = ~(sda_oe | s_sda | t_pull);
  int         n_fail = 0, tests_run = 0, hi = 0;
  int         exp_q[$];

  ims_i2c_master_sequencer ims_i2c_master_sequencer_inst (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_i(scl), .scl_o(scl_lv), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_lv), .sda_oe(sda_oe), .busy(busy));
  ims_slave_model #(.DEV(DEV)) ims_slave_model_inst (.scl(scl), .sda(sda),
    .stretch(stretch), .tx_byte(tx_byte), .scl_pull(s_scl), .sda_pull(s_sda),
    .rx_byte(rx_byte));

  initial
  begin
    forever #20 clock = ~clock;
  end

  task automatic complete_run();
    $display("Counts: %0d compared, %0d bad", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_flag(input logic [7:0] m);
    int k;
    for (k = 0; k < 3000; k++)
    begin
      rd(ADDR_FLAG, f);
      if ((f & m) != 8'h00)
        break;
    end
    if (k == 3000)
    begin
      n_fail++;
      complete_run();
    end
  endtask

  // One byte out, with a refused buffer write and a refused restart meanwhile
  task automatic send(input logic [7:0] b, input logic ack_b);
    exp_q.push_back(b);
    wr(ADDR_BUF, b);
    rd(ADDR_STAT, d);
    chk({7'h0, d[STAT_BF_POS]}, 8'h01);
    wr(ADDR_BUF, ~b);
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_FLAG, d);
    chk({7'h0, d[1]}, 8'h01);
    wait_flag(8'h01);
    chk(rx_byte, 8'(exp_q.pop_front()));
    rd(ADDR_CTRL, d);
    chk({6'h0, d[CTRL_ACK_POS], d[1]}, {6'h0, ack_b, 1'b0});
    rd(ADDR_STAT, d);
    chk({6'h0, d[STAT_BF_POS], scl}, 8'h00);
    wr(ADDR_FLAG, 8'h1f);
  endtask

  // High time of the bus clock never shorter than one baud period
  always @(posedge clock)
    if (scl)
      hi <= hi + 1;
    else
    begin
      if (hi > 0)
        chk({7'h0, hi >= 4}, 8'h01);
      hi <= 0;
    end

  initial
  begin
    void'($urandom(33373));
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rd(ADDR_BAUD, d);
    chk(d, BAUD_RST);
    rd(3'h5, d);
    chk(d, DATA_ZERO);
    rd(ADDR_STAT, d);
    chk(d, DATA_ZERO);
    $display("Test reset done");
    wr(ADDR_BAUD, 8'h03);
    t_pull <= 1'b1;
    repeat (3) @(posedge clock);
    wr(ADDR_CTRL, 8'h01);
    wait_flag(8'h04);
    t_pull <= 1'b0;
    chk({5'h0, busy, sda_oe, scl_oe}, 8'h00);
    chk({6'h0, scl_lv, sda_lv}, 8'h00);
    wr(ADDR_FLAG, 8'h1f);
    $display("Test collision done");
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_CTRL, 8'h01);
      wr(ADDR_CTRL, 8'h04);
      wr(ADDR_BUF, 8'h00);
      wait_flag(8'h01);
      rd(ADDR_FLAG, d);
      chk(d, 8'h0b);
      rd(ADDR_CTRL, d);
      chk({3'h0, d[4:0]}, 8'h00);
      chk({6'h0, sda, scl}, 8'h01);
      wr(ADDR_FLAG, 8'h1f);
      send({(i == 1) ? DEV : ~DEV, 1'b0}, i == 0);
      if (i == 1)
      begin
        stretch <= 1'b1;
        send(8'($urandom), 1'b0);
        stretch <= 1'b0;
        tx_byte <= 8'($urandom);
        wr(ADDR_CTRL, 8'h02);
        wait_flag(8'h01);
        rd(ADDR_FLAG, d);
        chk(d, 8'h09);
        chk({6'h0, sda, scl}, 8'h00);
        wr(ADDR_FLAG, 8'h1f);
        send({DEV, 1'b1}, 1'b0);
        wr(ADDR_CTRL, 8'h08);
        wait_flag(8'h01);
        rd(ADDR_STAT, d);
        chk({7'h0, d[STAT_BF_POS]}, 8'h01);
        rd(ADDR_BUF, d);
        chk(d, tx_byte);
        rd(ADDR_CTRL, d);
        chk({3'h0, d[4:0]}, 8'h00);
        wr(ADDR_FLAG, 8'h1f);
        wr(ADDR_CTRL, 8'h30);
        wait_flag(8'h01);
        rd(ADDR_CTRL, d);
        chk({3'h0, d[4:0]}, 8'h00);
        chk({6'h0, sda, scl}, 8'h02);
        wr(ADDR_FLAG, 8'h1f);
      end
      wr(ADDR_CTRL, 8'h04);
      wait_flag(8'h01);
      rd(ADDR_FLAG, d);
      chk(d, 8'h11);
      chk({5'h0, busy, sda, scl}, 8'h03);
      wr(ADDR_FLAG, 8'h1f);
      $display("Test transfer %0d done", i);
    end
    complete_run();
  end
endmodule
